// ---- verilog/urxb_pkg.sv ----
// urxb_pkg: constants for the serial receive buffer block
// assumes: single 50 MHz clock, register port with one-cycle read latency
package urxb_pkg;
  localparam logic [2:0] URXB_ADDR_DATA   = 3'h0;
  localparam logic [2:0] URXB_ADDR_STAT_A = 3'h1;
  localparam logic [2:0] URXB_ADDR_CTRL_B = 3'h2;
  localparam logic [2:0] URXB_ADDR_CTRL_C = 3'h3;
  localparam logic [2:0] URXB_ADDR_BAUD   = 3'h4;
  // status a fields
  localparam int URXB_A_RXC  = 7;
  localparam int URXB_A_FE   = 4;
  localparam int URXB_A_DOR  = 3;
  localparam int URXB_A_UPE  = 2;
  localparam int URXB_A_U2X  = 1;
  // control b fields
  localparam int URXB_B_RXCIE = 7;
  localparam int URXB_B_RXEN  = 4;
  localparam int URXB_B_SZ2   = 2;
  localparam int URXB_B_RXB8  = 1;
  // control c fields
  localparam int URXB_C_UPM1 = 5;
  localparam int URXB_C_UPM0 = 4;
  localparam int URXB_C_USBS = 3;
  localparam int URXB_C_SZ1  = 2;
  localparam int URXB_C_SZ0  = 1;
  // reset values
  localparam logic [7:0]  URXB_CTRL_B_RST = 8'h00;
  localparam logic [7:0]  URXB_CTRL_C_RST = 8'h06;
  localparam logic [15:0] URXB_BAUD_RST   = 16'h0000;
  localparam logic        URXB_U2X_RST    = 1'b0;
  // sampling
  localparam logic [3:0] URXB_SAMP_N_LAST = 4'hf;
  localparam logic [3:0] URXB_SAMP_D_LAST = 4'h7;
  localparam logic [3:0] URXB_MID_N       = 4'h9;
  localparam logic [3:0] URXB_MID_D       = 4'h5;
  localparam logic [2:0] URXB_SIZE_NINE   = 3'h7;
  localparam int         URXB_DEPTH       = 2;
endpackage : urxb_pkg

// ---- verilog/urxb_top.sv ----
// urxb_top: serial receiver with two-entry buffer and error status
// assumes: rx_line from a remote transmitter, registers on a plain port
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module urxb_top (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       global_irq_enable,
  input  wire logic       rx_line,
  output logic            rx_pin_override,
  output logic            rx_complete_irq
);
  typedef enum logic [1:0] {
    URXB_IDLE  = 2'b00,
    URXB_START = 2'b01,
    URXB_BITS  = 2'b10
  } urxb_state_t;

  // ------------------------------------------------------------
  // reset and input synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  logic [2:0] rx_sync_reg;
  logic       rx_level_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_reg  <= 3'b111;
      rx_level_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_line};
      if (rx_sync_reg[1] == rx_sync_reg[2]) rx_level_reg <= rx_sync_reg[2];
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  ctrl_c_reg;
  logic [15:0] baud_reg;
  logic        u2x_reg;
  logic        rx_enable;
  logic        parity_on;
  logic [2:0]  size_sel;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b_reg <= urxb_pkg::URXB_CTRL_B_RST;
      ctrl_c_reg <= urxb_pkg::URXB_CTRL_C_RST;
      baud_reg   <= urxb_pkg::URXB_BAUD_RST;
      u2x_reg    <= urxb_pkg::URXB_U2X_RST;
    end else if (reg_write) begin
      unique case (reg_addr)
        urxb_pkg::URXB_ADDR_CTRL_B: ctrl_b_reg <= reg_wdata;
        urxb_pkg::URXB_ADDR_CTRL_C: ctrl_c_reg <= reg_wdata;
        urxb_pkg::URXB_ADDR_BAUD:   baud_reg[7:0] <= reg_wdata;
        // error flag positions ignore writes
        urxb_pkg::URXB_ADDR_STAT_A:
          u2x_reg <= reg_wdata[urxb_pkg::URXB_A_U2X];
        default: ;
      endcase
    end
  end
  assign rx_enable = ctrl_b_reg[urxb_pkg::URXB_B_RXEN];
  assign parity_on = ctrl_c_reg[urxb_pkg::URXB_C_UPM1];
  assign size_sel  = {ctrl_b_reg[urxb_pkg::URXB_B_SZ2],
                      ctrl_c_reg[urxb_pkg::URXB_C_SZ1],
                      ctrl_c_reg[urxb_pkg::URXB_C_SZ0]};
  assign rx_pin_override = rx_enable;

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  // ------------------------------------------------------------
  // sample tick at sixteen or eight per bit
  // ------------------------------------------------------------
  // only the low divider byte is writable; the upper byte stays zero
  logic [15:0] div_reg;
  logic        tick;
  assign tick = (div_reg == 16'h0000);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) div_reg <= 16'h0000;
    else if (tick) div_reg <= baud_reg;
    else div_reg <= div_reg - 16'h0001;
  end

  // ------------------------------------------------------------
  // clock and data recovery
  // ------------------------------------------------------------
  urxb_state_t state_reg;
  logic [3:0]  samp_reg;
  logic [1:0]  win_reg;
  logic [2:0]  vote_win;
  logic [3:0]  bit_reg;
  logic [3:0]  nbits;
  logic [9:0]  shift_reg;
  logic        par_reg;
  logic        shift_full_reg;
  logic        push;
  logic        start_ok;
  logic [3:0]  samp_last;
  logic [3:0]  samp_mid;
  logic        bit_val;
  logic [3:0]  ndata;
  always_comb begin
    samp_last = u2x_reg ? urxb_pkg::URXB_SAMP_D_LAST
                        : urxb_pkg::URXB_SAMP_N_LAST;
    samp_mid  = u2x_reg ? urxb_pkg::URXB_MID_D : urxb_pkg::URXB_MID_N;
    ndata = (size_sel == urxb_pkg::URXB_SIZE_NINE) ? 4'd9
          : 4'd5 + {2'b00, size_sel[1:0]};
    nbits = ndata + {3'b000, parity_on} + 4'd1;
  end
  // vote on the two previous samples and the one taken at this tick
  assign vote_win = {win_reg, rx_level_reg};
  assign bit_val  = maj3(vote_win);
  logic fifo_full;
  // a confirmed start bit, as seen by the overrun check
  assign start_ok = tick && state_reg == URXB_START &&
                    samp_reg == samp_mid + 4'd1 && !bit_val;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= URXB_IDLE;
      samp_reg  <= 4'h0;
      win_reg   <= 2'b11;
      bit_reg   <= 4'h0;
      shift_reg <= 10'h000;
      par_reg   <= 1'b0;
    end else if (!rx_enable) begin
      state_reg <= URXB_IDLE;
    end else if (tick) begin
      win_reg  <= {win_reg[0], rx_level_reg};
      samp_reg <= samp_reg + 4'd1;
      unique case (state_reg)
        URXB_IDLE: if (!rx_level_reg) begin
          state_reg <= URXB_START;
          samp_reg  <= 4'd2;
        end
        URXB_START: if (samp_reg == samp_mid + 4'd1) begin
          if (bit_val) state_reg <= URXB_IDLE;
        end else if (samp_reg == samp_last) begin
          state_reg <= URXB_BITS;
          samp_reg  <= 4'd0;
          bit_reg   <= 4'd0;
          par_reg   <= 1'b0;
        end
        URXB_BITS: if (samp_reg == samp_mid + 4'd1) begin
          // a nine-bit parity frame puts its stop bit past the register
          if (bit_reg < 4'd10) shift_reg[bit_reg] <= bit_val;
          if (bit_reg < ndata) par_reg <= par_reg ^ bit_val;
          if (bit_reg == nbits - 4'd1) state_reg <= URXB_IDLE;
        end else if (samp_reg == samp_last) begin
          samp_reg <= 4'd0;
          bit_reg  <= bit_reg + 4'd1;
        end
        default: state_reg <= URXB_IDLE;
      endcase
    end
  end

  // frame done at first stop bit vote; stop count ignored
  logic       frame_done;
  logic [8:0] fr_data;
  logic       fr_stop;
  logic       fr_par;
  logic       fr_perr;
  assign frame_done = rx_enable && tick && state_reg == URXB_BITS &&
                      samp_reg == samp_mid + 4'd1 &&
                      bit_reg == nbits - 4'd1;
  always_comb begin
    fr_data = 9'h000;
    for (int i = 0; i < 9; i++)
      if (i < int'(ndata)) fr_data[i] = shift_reg[i];
    fr_par  = parity_on ? shift_reg[ndata] : 1'b0;
    fr_stop = bit_val;
    // even with low bit zero, odd with one
    fr_perr = parity_on &&
      ((par_reg ^ fr_par) != ctrl_c_reg[urxb_pkg::URXB_C_UPM0]);
  end

  // ------------------------------------------------------------
  // shift holding stage and two-entry fifo
  // ------------------------------------------------------------
  logic [8:0] hold_data_reg;
  logic       hold_fe_reg;
  logic       hold_pe_reg;
  logic       dor_reg;
  logic [8:0] fifo_data [urxb_pkg::URXB_DEPTH];
  logic [2:0] fifo_err  [urxb_pkg::URXB_DEPTH];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       pop;
  assign fifo_full = (count_reg == 2'd2);
  assign pop  = reg_read && reg_addr == urxb_pkg::URXB_ADDR_DATA &&
                count_reg != 2'd0;
  assign push = shift_full_reg && (!fifo_full || pop);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_full_reg <= 1'b0;
      hold_data_reg  <= 9'h000;
      hold_fe_reg    <= 1'b0;
      hold_pe_reg    <= 1'b0;
      dor_reg        <= 1'b0;
    end else if (!rx_enable) begin
      shift_full_reg <= 1'b0;
      dor_reg        <= 1'b0;
    end else begin
      if (frame_done) begin
        shift_full_reg <= 1'b1;
        hold_data_reg  <= fr_data;
        hold_fe_reg    <= !fr_stop;
        hold_pe_reg    <= fr_perr;
      end else if (push) begin
        shift_full_reg <= 1'b0;
      end
      if (fifo_full && shift_full_reg && !pop && start_ok)
        dor_reg <= 1'b1;
      else if (push)
        dor_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end else if (!rx_enable) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end else begin
      if (push) wr_ptr_reg <= !wr_ptr_reg;
      if (pop) rd_ptr_reg <= !rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      fifo_data[wr_ptr_reg] <= hold_data_reg;
      // status travels with its frame
      fifo_err[wr_ptr_reg]  <= {hold_fe_reg, dor_reg, hold_pe_reg};
    end
  end

  // ------------------------------------------------------------
  // read port and interrupt
  // ------------------------------------------------------------
  logic       rxc;
  logic [8:0] head_data;
  logic [2:0] head_err;
  logic [7:0] rdata_next;
  // disabling hides the buffer at once, before the flush lands
  assign rxc       = rx_enable &&
                     (count_reg != 2'd0);
  assign head_data = rxc ? fifo_data[rd_ptr_reg] : 9'h000;
  assign head_err  = rxc ? fifo_err[rd_ptr_reg] : 3'b000;
  // error flags take no part in the request
  assign rx_complete_irq = rxc && global_irq_enable &&
                           ctrl_b_reg[urxb_pkg::URXB_B_RXCIE];

  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      urxb_pkg::URXB_ADDR_DATA:   rdata_next = head_data[7:0];
      urxb_pkg::URXB_ADDR_STAT_A: begin
        rdata_next[urxb_pkg::URXB_A_RXC] = rxc;
        rdata_next[urxb_pkg::URXB_A_FE]  = head_err[2];
        rdata_next[urxb_pkg::URXB_A_DOR] = head_err[1];
        rdata_next[urxb_pkg::URXB_A_UPE] = head_err[0];
        rdata_next[urxb_pkg::URXB_A_U2X] = u2x_reg;
      end
      urxb_pkg::URXB_ADDR_CTRL_B: begin
        rdata_next = ctrl_b_reg;
        rdata_next[urxb_pkg::URXB_B_RXB8] = head_data[8];
      end
      urxb_pkg::URXB_ADDR_CTRL_C: rdata_next = ctrl_c_reg;
      urxb_pkg::URXB_ADDR_BAUD:   rdata_next = baud_reg[7:0];
      default:                    rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_read) reg_rdata <= rdata_next;
    else reg_rdata <= 8'h00;
  end
endmodule : urxb_top

// ---- test/urxb_asserts.sv ----
// urxb_asserts: port-level checks of the serial receive buffer block
// assumes: bound to urxb_top, one clock domain, reset low active
`timescale 1ns/1ns
module urxb_asserts (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       global_irq_enable,
  input wire logic       rx_line,
  input wire logic       rx_pin_override,
  input wire logic       rx_complete_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic wr_b;
  assign wr_b = reg_write && reg_addr == urxb_pkg::URXB_ADDR_CTRL_B;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_unmapped_zero: assert property (
    reg_read && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_gated: assert property (
    !global_irq_enable |-> !rx_complete_irq)
    else $error("interrupt without global enable");
  a_irq_holds: assert property (
    rx_complete_irq && !reg_read && !reg_write ##1 global_irq_enable
    |-> rx_complete_irq)
    else $error("interrupt dropped while frame unread");
  a_flush_clears: assert property (
    wr_b && !reg_wdata[urxb_pkg::URXB_B_RXEN] |=> !rx_complete_irq [*4])
    else $error("buffer not flushed on receiver disable");
  a_irq_needs_en: assert property (
    wr_b && !reg_wdata[urxb_pkg::URXB_B_RXCIE] |=> !rx_complete_irq)
    else $error("interrupt with enable cleared");
  a_override_follow: assert property (
    wr_b |=> rx_pin_override == $past(reg_wdata[urxb_pkg::URXB_B_RXEN]))
    else $error("pin override not following receiver enable");
  a_rxc_in_status: assert property (
    reg_read && reg_addr == urxb_pkg::URXB_ADDR_STAT_A && rx_complete_irq
    |=> reg_rdata[urxb_pkg::URXB_A_RXC])
    else $error("receive complete not shown in status");
  c_irq: cover property (rx_complete_irq);
  c_pop: cover property (reg_read && reg_addr == 3'h0 && rx_complete_irq);
  c_start: cover property (rx_pin_override && $fell(rx_line));
endmodule : urxb_asserts

bind urxb_top urxb_asserts u_asserts (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
  .rx_line(rx_line), .rx_pin_override(rx_pin_override),
  .rx_complete_irq(rx_complete_irq));

// ---- test/urxb_serial_src.sv ----
// urxb_serial_src: remote asynchronous transmitter on the receive line
// assumes: tasks called by the bench just after a rising clock edge
`timescale 1ns/1ns
module urxb_serial_src (
  input wire logic clock,
  output logic     line
);
  initial line = 1'b1;
  task automatic hold_bit(input logic b, input int clks);
    line <= b;
    repeat (clks) @(posedge clock);
  endtask : hold_bit
  task automatic send(input logic [8:0] v, input int n, input logic pe,
                      input logic po, input logic pb, input logic st,
                      input int clks);
    logic p;
    p = po; // odd seeds one
    hold_bit(1'b0, clks);
    for (int i = 0; i < n; i++) begin
      p ^= v[i];
      hold_bit(v[i], clks); // lsb first
    end
    if (pe) hold_bit(p ^ pb, clks);
    hold_bit(st, clks);
    if (!st) hold_bit(1'b1, clks);
  endtask : send
endmodule : urxb_serial_src

// ---- test/testbench.sv ----
// testbench: register port driver, serial source and read checker
// assumes: urxb_top with the register map of urxb_pkg
`timescale 1ns/1ns
module testbench;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       global_irq_enable = 1'b0;
  logic [7:0] reg_rdata;
  logic       rx_line, rx_pin_override, rx_complete_irq, rd_pend = 1'b0;
  logic [7:0] exp_q[$], msk_q[$], d[4];
  int         error_cnt = 0, checked = 0, seed = 32'h0000_76a1, bclk;
  int         baud;
  always #10 clock = ~clock;
  urxb_top u_dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
    .rx_line(rx_line), .rx_pin_override(rx_pin_override),
    .rx_complete_irq(rx_complete_irq));
  urxb_serial_src u_src (.clock(clock), .line(rx_line));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask : rd
  task automatic tx(input logic [8:0] v, input int n, input logic pe,
                    input logic po, input logic pb, input logic st);
    u_src.send(v, n, pe, po, pb, st, bclk);
    repeat (4) @(posedge clock);
  endtask : tx
  // read answers are checked in order of request
  always @(posedge clock) begin
    if (rd_pend) check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    rd_pend <= reg_read;
  end
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [8:0] v, w;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(3'h2, urxb_pkg::URXB_CTRL_B_RST);
    rd(3'h3, urxb_pkg::URXB_CTRL_C_RST);
    rd(3'h6, 8'h00);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h00);
    baud = {$random(seed)} % 3;
    bclk = 16 * (baud + 1);
    wr(3'h4, baud[7:0]);
    wr(3'h2, 8'h10);
    u_src.hold_bit(1'b0, 4 * (baud + 1));
    u_src.hold_bit(1'b1, bclk);
    rd(3'h1, 8'h00);
    $display("test registers and noise done");
    for (int i = 0; i < 4; i++) begin
      d[i] = $random(seed);
      u_src.send({1'b0, d[i]}, 8, 1'b0, 1'b0, 1'b0, 1'b1, bclk);
    end
    repeat (4) @(posedge clock);
    rd(3'h1, 8'h80);
    rd(3'h0, d[0]);
    rd(3'h1, 8'h80);
    rd(3'h0, d[1]);
    rd(3'h1, 8'h88, 8'h88);
    rd(3'h0, d[3]);
    tx({1'b0, d[2]}, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(3'h1, 8'h80);
    wr(3'h2, 8'h00);
    rd(3'h1, 8'h00);
    check({7'h00, rx_pin_override}, 8'h00);
    wr(3'h2, 8'h10);
    tx({1'b0, d[3]}, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(3'h1, 8'h80);
    rd(3'h0, d[3]);
    $display("test overrun and flush done");
    for (int k = 0; k < 4; k++) begin
      wr(3'h3, {3'b001, k[0], 4'h6});
      v = $random(seed);
      tx(v, 8, 1'b1, k[0], k[1], 1'b1);
      rd(3'h1, k[1] ? 8'h84 : 8'h80);
      rd(3'h0, v[7:0]);
    end
    $display("test parity done");
    wr(3'h3, 8'h0e);
    v = $random(seed);
    w = $random(seed);
    tx(v, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    tx(w, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h90);
    rd(3'h0, v[7:0]);
    rd(3'h1, 8'h80);
    rd(3'h0, w[7:0]);
    wr(3'h3, 8'h06);
    $display("test framing done");
    wr(3'h2, 8'h14);
    v = {1'b1, 8'($random(seed))};
    w = {1'b0, 8'($random(seed))};
    tx(v, 9, 1'b0, 1'b0, 1'b0, 1'b1);
    tx(w, 9, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(3'h2, 8'h16);
    rd(3'h0, v[7:0]);
    rd(3'h2, 8'h14);
    rd(3'h0, w[7:0]);
    rd(3'h1, 8'h00);
    $display("test nine bits done");
    wr(3'h2, 8'h10);
    wr(3'h1, 8'h02);
    bclk = 8 * (baud + 1);
    v = $random(seed);
    tx(v, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(3'h1, 8'h82);
    rd(3'h0, v[7:0]);
    wr(3'h1, 8'h00);
    bclk = 16 * (baud + 1);
    $display("test double speed done");
    global_irq_enable <= 1'b1;
    wr(3'h2, 8'h90);
    v = $random(seed);
    tx(v, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    check({7'h00, rx_complete_irq}, 8'h01);
    global_irq_enable <= 1'b0;
    @(posedge clock);
    check({7'h00, rx_complete_irq}, 8'h00);
    global_irq_enable <= 1'b1;
    rd(3'h0, v[7:0]);
    @(posedge clock);
    check({7'h00, rx_complete_irq}, 8'h00);
    v = $random(seed);
    tx(v, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    check({7'h00, rx_complete_irq}, 8'h01);
    wr(3'h2, 8'h80);
    @(posedge clock);
    check({7'h00, rx_complete_irq}, 8'h00);
    $display("test interrupt done");
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule : testbench
